/* File: src/bsa_defines.svh */
`ifndef BSA_DEFINES_SVH
`define BSA_DEFINES_SVH

// APB register map (byte addresses)
`define BSA_ADDR_W       8
`define BSA_OFF_CMD      8'h00
`define BSA_OFF_ACC      8'h04
`define BSA_OFF_STATUS   8'h08
`define BSA_OFF_WDOG     8'h0C
`define BSA_OFF_CTRL     8'h10
`define BSA_MEM_BASE     2'h1
`define BSA_MEM_DEPTH    16

// Command register fields
`define BSA_CMD_OP_LSB   0
`define BSA_CMD_OP_W     3
`define BSA_CMD_MA_LSB   8
`define BSA_CMD_MA_W     4

// Command codes
`define BSA_OP_BCD       3'h1
`define BSA_OP_SUB_MEM   3'h2
`define BSA_OP_SUB_ACC   3'h3
`define BSA_OP_ADD_MEM   3'h4
`define BSA_OP_ADD_ACC   3'h5
`define BSA_OP_HALT      3'h6

// Status register fields
`define BSA_ST_OVF       0
`define BSA_ST_HALF      1
`define BSA_ST_NIL       2
`define BSA_ST_SLEEP     3
`define BSA_ST_WDX       4
`define BSA_ST_W         5

// Control register fields
`define BSA_CTRL_WAKE    0
`define BSA_CTRL_WDCLR   1

// Decimal correction constants
`define BSA_BCD_LIMIT    4'h9
`define BSA_BCD_FIX      4'h6

// Watchdog sizes and accumulator and status reset values
`define BSA_PRESCALE_W   8
`define BSA_WDOG_W       8
`define BSA_RST_ACC      8'h00
`define BSA_RST_STATUS   5'h00

`endif

/* File: src/bsa_pkg.sv */
package bsa_pkg;

  typedef enum logic [1:0]
  {
    BSA_RUN   = 2'b01,
    BSA_SLEEP = 2'b10
  } bsa_state_type;

  typedef logic [7:0] bsa_byte_type;

endpackage

/* File: src/bsa_datapath.sv */
// Overview of operation
// (RULE1) Decimal correction adds six to the low nibble when it is above nine or half carry is set.
// (RULE2) Decimal correction adds six to the high nibble when it is above nine or overflow is set.
// (RULE3) Decimal correction adds 00H, 06H, 60H or 66H to the accumulator and stores it in memory.
// (RULE4) Decimal correction touches only the overflow flag, setting it when the sum passes 99.
// (RULE5) Subtract-one-in-place writes memory minus one back and updates only the nil flag.
// (RULE6) Subtract-one-to-accumulator loads memory minus one, keeps memory, updates only nil.
// (RULE7) Add-one-in-place writes memory plus one back and updates only the nil flag.
// (RULE8) Add-one-to-accumulator loads memory plus one, keeps memory, updates only nil.
// (RULE9) Power-down stops execution and the system clock while memory and registers hold.
// (RULE10) Power-down clears the watchdog counter and its prescaler.
// (RULE11) Power-down sets the sleep flag, clears the watchdog expired flag, nothing else.
// (RULE12) Increment and decrement wrap modulo 256 and nil is set exactly on a zero result.
// (RULE13) A carry out of the low-nibble correction reaches the high nibble before its test.
//
// Our own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "bsa_defines.svh"

module bsa_datapath #(
  parameter int PRE_W = `BSA_PRESCALE_W,
  parameter int WDOG_W = `BSA_WDOG_W
) (
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`BSA_ADDR_W-1:0]   paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Core status
  output logic                          sys_clk_en,
  output logic                          exec_halted
);
  import bsa_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [8:0] bcd_fix(input logic [7:0] a, input logic hc, input logic oc);
    logic [8:0] s;
    s = {1'b0, a};
    if ((a[3:0] > `BSA_BCD_LIMIT) || hc)
      s = s + {5'h00, `BSA_BCD_FIX};
    if ((s[7:4] > `BSA_BCD_LIMIT) || s[8] || oc)
      s = s + {1'b0, `BSA_BCD_FIX, 4'h0};
    bcd_fix = {oc | s[8], s[7:0]};
  endfunction

  function automatic logic hit(input logic [`BSA_ADDR_W-1:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State

  bsa_state_type               state;
  bsa_state_type               next_state;
  bsa_byte_type                acc;
  bsa_byte_type                next_acc;
  logic [`BSA_ST_W-1:0]        flags;
  logic [`BSA_ST_W-1:0]        next_flags;
  logic [PRE_W-1:0]            pre;
  logic [PRE_W-1:0]            next_pre;
  logic [WDOG_W-1:0]           wdog;
  logic [WDOG_W-1:0]           next_wdog;
  logic [31:0]                 next_prdata;
  logic                        next_pready;
  logic                        next_pslverr;
  logic                        next_clk_en;
  logic                        next_halted;
  bsa_byte_type                mem [`BSA_MEM_DEPTH];
  logic                        mem_we;
  logic [`BSA_CMD_MA_W-1:0]    mem_wa;
  bsa_byte_type                mem_wd;

  logic                        is_mem;
  logic                        mapped;
  logic                        commit;
  logic                        exec;
  logic [`BSA_CMD_OP_W-1:0]    op;
  logic [`BSA_CMD_MA_W-1:0]    ma;
  bsa_byte_type                opnd;
  bsa_byte_type                inc_v;
  bsa_byte_type                sub_v;
  logic                        wd_clr;
  logic [8:0]                  bcd_v;
  logic [31:0]                 rd_v;

  ////////////////////////////////////////////////////////////////////////////////
  // Decode

  always_comb
  begin
    is_mem = (paddr[7:6] == `BSA_MEM_BASE);
    mapped = is_mem || hit(paddr, `BSA_OFF_CMD) || hit(paddr, `BSA_OFF_ACC)
             || hit(paddr, `BSA_OFF_STATUS) || hit(paddr, `BSA_OFF_WDOG)
             || hit(paddr, `BSA_OFF_CTRL);
    commit = psel && penable && pready && pwrite && !pslverr;
    op     = pwdata[`BSA_CMD_OP_LSB +: `BSA_CMD_OP_W];
    ma     = pwdata[`BSA_CMD_MA_LSB +: `BSA_CMD_MA_W];
    exec   = commit && hit(paddr, `BSA_OFF_CMD) && (state == BSA_RUN); // RULE9
    wd_clr = commit && hit(paddr, `BSA_OFF_CTRL) && pwdata[`BSA_CTRL_WDCLR];
    opnd   = mem[ma];
    inc_v  = opnd + 8'h01; // RULE12
    sub_v  = opnd - 8'h01; // RULE12
    bcd_v  = bcd_fix(acc, flags[`BSA_ST_HALF], flags[`BSA_ST_OVF]); // RULE13
    rd_v   = 32'h0000_0000;
    if (is_mem)
      rd_v = {24'h00_0000, mem[paddr[5:2]]};
    else if (hit(paddr, `BSA_OFF_ACC))
      rd_v = {24'h00_0000, acc};
    else if (hit(paddr, `BSA_OFF_STATUS))
      rd_v = {27'h000_0000, flags};
    else if (hit(paddr, `BSA_OFF_WDOG))
      rd_v = 32'(wdog);
    else if (hit(paddr, `BSA_OFF_CTRL))
      rd_v = {30'h0000_0000, 1'b0, state == BSA_SLEEP};
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    next_state   = state;
    next_acc     = acc;
    next_flags   = flags;
    next_pre     = pre;
    next_wdog    = wdog;
    next_prdata  = prdata;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    mem_we       = 1'b0;
    mem_wa       = ma;
    mem_wd       = 8'h00;
    if (psel && penable && !pready)
    begin
      next_pready  = 1'b1;
      next_pslverr = !mapped;
      next_prdata  = pwrite ? 32'h0000_0000 : rd_v;
    end
    if (commit)
    begin
      if (is_mem)
      begin
        mem_we = 1'b1;
        mem_wa = paddr[5:2];
        mem_wd = pwdata[7:0];
      end
      if (hit(paddr, `BSA_OFF_ACC))
        next_acc = pwdata[7:0];
      if (hit(paddr, `BSA_OFF_STATUS))
        next_flags = pwdata[`BSA_ST_W-1:0];
      if (hit(paddr, `BSA_OFF_CTRL))
      begin
        if (pwdata[`BSA_CTRL_WAKE])
          next_state = BSA_RUN;
        if (pwdata[`BSA_CTRL_WDCLR])
        begin
          next_pre                = '0;
          next_wdog               = '0;
          next_flags[`BSA_ST_WDX] = 1'b0;
          next_flags[`BSA_ST_SLEEP] = 1'b0;
        end
      end
    end
    if (state == BSA_RUN)
    begin
      if (!wd_clr)
      begin
        next_pre = pre + 1'b1;
        if (&pre)
          next_wdog = wdog + 1'b1;
      end
      if (&pre && &wdog)
        next_flags[`BSA_ST_WDX] = 1'b1;
    end
    if (exec)
    begin
      unique case (op)
        `BSA_OP_BCD:
        begin
          mem_we                  = 1'b1; // RULE3
          mem_wd                  = bcd_v[7:0]; // RULE1 RULE2 RULE3
          next_flags[`BSA_ST_OVF] = bcd_v[8]; // RULE4
        end
        `BSA_OP_SUB_MEM:
        begin
          mem_we                  = 1'b1; // RULE5
          mem_wd                  = sub_v; // RULE5
          next_flags[`BSA_ST_NIL] = (sub_v == 8'h00); // RULE5 RULE12
        end
        `BSA_OP_SUB_ACC:
        begin
          next_acc                = sub_v; // RULE6
          next_flags[`BSA_ST_NIL] = (sub_v == 8'h00); // RULE6 RULE12
        end
        `BSA_OP_ADD_MEM:
        begin
          mem_we                  = 1'b1; // RULE7
          mem_wd                  = inc_v; // RULE7
          next_flags[`BSA_ST_NIL] = (inc_v == 8'h00); // RULE7 RULE12
        end
        `BSA_OP_ADD_ACC:
        begin
          next_acc                = inc_v; // RULE8
          next_flags[`BSA_ST_NIL] = (inc_v == 8'h00); // RULE8 RULE12
        end
        `BSA_OP_HALT:
        begin
          next_state                = BSA_SLEEP; // RULE9
          next_pre                  = '0; // RULE10
          next_wdog                 = '0; // RULE10
          next_flags[`BSA_ST_SLEEP] = 1'b1; // RULE11
          next_flags[`BSA_ST_WDX]   = 1'b0; // RULE11
        end
        default:
        begin
          next_state = state;
        end
      endcase
    end
    next_clk_en = (next_state == BSA_RUN); // RULE9
    next_halted = (next_state == BSA_SLEEP);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state       <= BSA_RUN;
      acc         <= `BSA_RST_ACC;
      flags       <= `BSA_RST_STATUS;
      pre         <= '0;
      wdog        <= '0;
      prdata      <= 32'h0000_0000;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      sys_clk_en  <= 1'b1;
      exec_halted <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      acc         <= next_acc;
      flags       <= next_flags;
      pre         <= next_pre;
      wdog        <= next_wdog;
      prdata      <= next_prdata;
      pready      <= next_pready;
      pslverr     <= next_pslverr;
      sys_clk_en  <= next_clk_en;
      exec_halted <= next_halted;
    end
  end

  always_ff @(posedge pclk)
  begin
    if (mem_we)
      mem[mem_wa] <= mem_wd;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_exec(logic [2:0] code);
    exec && (op == code);
  endsequence

  sequence s_low_fix;
    s_exec(`BSA_OP_BCD) && ((acc[3:0] > 4'h9) || flags[`BSA_ST_HALF]);
  endsequence

  a_low_nibble_fix: assert property (s_low_fix |=> // RULE1
    mem[$past(ma)][3:0] == 4'($past(acc[3:0]) + 4'h6))
    else $error("low nibble not corrected");

  a_high_overflow: assert property ((s_exec(`BSA_OP_BCD) && (acc[7:4] > 4'h9)) |=> // RULE2
    flags[`BSA_ST_OVF])
    else $error("high nibble correction missing carry");

  a_bcd_constant: assert property (s_exec(`BSA_OP_BCD) |=> // RULE3
    (mem[$past(ma)] == $past(acc)) || (mem[$past(ma)] == 8'($past(acc) + 8'h06))
    || (mem[$past(ma)] == 8'($past(acc) + 8'h60)) || (mem[$past(ma)] == 8'($past(acc) + 8'h66)))
    else $error("correction used an illegal constant");

  a_bcd_flags_kept: assert property (s_exec(`BSA_OP_BCD) |=> // RULE4
    (flags[3:1] == $past(flags[3:1])) && (acc == $past(acc))
    && ((flags[4] == $past(flags[4])) || $past(&pre && &wdog))
    && (flags[`BSA_ST_OVF] >= $past(flags[`BSA_ST_OVF])))
    else $error("correction disturbed other flags");

  a_sub_in_place: assert property (s_exec(`BSA_OP_SUB_MEM) |=> // RULE5
    (mem[$past(ma)] == 8'($past(opnd) - 8'h01)) && (acc == $past(acc)))
    else $error("decrement in place wrong");

  a_sub_to_acc: assert property (s_exec(`BSA_OP_SUB_ACC) |=> // RULE6
    (acc == 8'($past(opnd) - 8'h01)) && (mem[$past(ma)] == $past(opnd)))
    else $error("decrement to accumulator wrong");

  a_add_in_place: assert property (s_exec(`BSA_OP_ADD_MEM) |=> // RULE7
    (mem[$past(ma)] == 8'($past(opnd) + 8'h01)) && (acc == $past(acc)))
    else $error("increment in place wrong");

  a_add_to_acc: assert property (s_exec(`BSA_OP_ADD_ACC) |=> // RULE8
    (acc == 8'($past(opnd) + 8'h01)) && (mem[$past(ma)] == $past(opnd)))
    else $error("increment to accumulator wrong");

  a_halt_stops_clock: assert property (s_exec(`BSA_OP_HALT) |=> // RULE9
    !sys_clk_en && exec_halted && (acc == $past(acc)) && !exec)
    else $error("power-down did not stop the clock");

  a_halt_clears_wdog: assert property (s_exec(`BSA_OP_HALT) |=> // RULE10
    (wdog == '0) && (pre == '0) ##1 (wdog == '0) && (pre == '0))
    else $error("power-down left the watchdog running");

  a_halt_flag_update: assert property (s_exec(`BSA_OP_HALT) |=> // RULE11
    flags[`BSA_ST_SLEEP] && !flags[`BSA_ST_WDX] && (flags[2:0] == $past(flags[2:0])))
    else $error("power-down flag update wrong");

  a_nil_tracks_zero: assert property ((exec && (op >= `BSA_OP_SUB_MEM) // RULE12
    && (op <= `BSA_OP_ADD_ACC)) |=> flags[`BSA_ST_NIL] == (($past(op) == `BSA_OP_SUB_MEM
    || $past(op) == `BSA_OP_SUB_ACC) ? ($past(opnd) == 8'h01) : ($past(opnd) == 8'hFF)))
    else $error("nil flag wrong after step");

endmodule

/* File: tb/bsa_decoder_model.sv */
`timescale 1ns/1ps
`include "bsa_defines.svh"

module bsa_decoder_model (
  // Clock
  input  wire logic                   pclk,
  // APB request side
  output logic                        psel,
  output logic                        penable,
  output logic                        pwrite,
  output logic [`BSA_ADDR_W-1:0]      paddr,
  output logic [31:0]                 pwdata,
  // APB answer side
  input  wire logic [31:0]            prdata,
  input  wire logic                   pready,
  input  wire logic                   pslverr
);
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
  end

  // One transfer; request held until the rising edge that samples ready high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released bus shows no stale value
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
`include "bsa_defines.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end

module tb;
  import bsa_pkg::*;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sys_clk_en;
  logic        exec_halted;
  logic [31:0] rdat;
  logic        err;
  int          failures        = 0;
  int          samples_checked = 0;

  always #2 pclk = ~pclk;

  bsa_datapath #(.PRE_W(2), .WDOG_W(2)) bsa_datapath_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sys_clk_en(sys_clk_en), .exec_halted(exec_halted));

  bsa_decoder_model bsa_decoder_model_i (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bsa_decoder_model_i.xfer(1'b1, a, d, rdat, err);
  endtask

  task automatic rd(input logic [7:0] a);
    bsa_decoder_model_i.xfer(1'b0, a, 32'h0000_0000, rdat, err);
  endtask

  function automatic logic [7:0] ma(input int i);
    return {`BSA_MEM_BASE, i[3:0], 2'b00};
  endfunction

  task automatic cmd(input logic [2:0] op, input int i);
    wr(`BSA_OFF_CMD, {20'h0_0000, i[3:0], 5'h00, op});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_bcd;
    logic [7:0] ai[6] = '{8'h15, 8'h1A, 8'hA3, 8'h9A, 8'h12, 8'h12};
    logic [3:0] si[6] = '{4'h4, 4'h0, 4'h0, 4'h0, 4'h2, 4'h1};
    logic [7:0] ro[6] = '{8'h15, 8'h20, 8'h03, 8'h00, 8'h18, 8'h72};
    logic [3:0] so[6] = '{4'h4, 4'h0, 4'h1, 4'h1, 4'h2, 4'h1};
    rd(8'h20);
    `CHK("unmapped error", 1'b1, err)
    for (int i = 0; i < 6; i++)
    begin
      wr(`BSA_OFF_ACC, {24'h00_0000, ai[i]});
      wr(`BSA_OFF_STATUS, {28'h000_0000, si[i]});
      wr(ma(i), 32'h0000_0000);
      cmd(`BSA_OP_BCD, i);
      rd(ma(i));
      `CHK("bcd memory", {24'h00_0000, ro[i]}, rdat)
      rd(`BSA_OFF_STATUS);
      `CHK("bcd flags", so[i], rdat[3:0])
    end
  endtask

  task automatic test_incdec;
    logic [2:0] op[6] = '{`BSA_OP_SUB_MEM, `BSA_OP_SUB_MEM, `BSA_OP_SUB_ACC,
                          `BSA_OP_ADD_MEM, `BSA_OP_ADD_ACC, `BSA_OP_ADD_MEM};
    logic [7:0] mi[6] = '{8'h01, 8'h00, 8'h01, 8'hFF, 8'hFF, 8'h7F};
    logic [7:0] mo[6] = '{8'h00, 8'hFF, 8'h01, 8'h00, 8'hFF, 8'h80};
    logic [7:0] ao[6] = '{8'h55, 8'h55, 8'h00, 8'h55, 8'h00, 8'h55};
    logic       nz[6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 6; i++)
    begin
      wr(`BSA_OFF_ACC, 32'h0000_0055);
      wr(`BSA_OFF_STATUS, 32'h0000_0003);
      wr(ma(i), {24'h00_0000, mi[i]});
      cmd(op[i], i);
      rd(ma(i));
      `CHK("step memory", {24'h00_0000, mo[i]}, rdat)
      rd(`BSA_OFF_ACC);
      `CHK("step acc", {24'h00_0000, ao[i]}, rdat)
      rd(`BSA_OFF_STATUS);
      `CHK("step flags", {1'b0, nz[i], 2'b11}, rdat[3:0])
    end
  endtask

  task automatic test_halt;
    wr(`BSA_OFF_ACC, 32'h0000_003C);
    wr(ma(2), 32'h0000_0044);
    wr(`BSA_OFF_STATUS, 32'h0000_0013);
    cmd(`BSA_OP_HALT, 0);
    @(posedge pclk);
    #1;
    `CHK("halted", 1'b1, exec_halted)
    `CHK("clock enable", 1'b0, sys_clk_en)
    rd(`BSA_OFF_WDOG);
    `CHK("watchdog", 32'h0000_0000, rdat)
    rd(`BSA_OFF_STATUS);
    `CHK("halt flags", 32'h0000_000B, rdat)
    cmd(`BSA_OP_ADD_MEM, 2);
    rd(ma(2));
    `CHK("held memory", 32'h0000_0044, rdat)
    rd(`BSA_OFF_ACC);
    `CHK("held acc", 32'h0000_003C, rdat)
    repeat (20) @(posedge pclk);
    rd(`BSA_OFF_WDOG);
    `CHK("frozen watchdog", 32'h0000_0000, rdat)
    wr(`BSA_OFF_CTRL, 32'h0000_0001);
    @(posedge pclk);
    #1;
    `CHK("woken", 1'b1, sys_clk_en)
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("Checks %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    test_bcd();
    test_incdec();
    test_halt();
    end_of_test();
  end

  initial
  begin
    repeat (3000) @(posedge pclk);
    failures++;
    end_of_test();
  end
endmodule
